// *** core/led_port_pkg.sv ***
// constants for the write-only serial register port
`default_nettype none
package led_port_pkg;
	localparam logic [4:0] ADDR_UPPER = 5'h1B;
	localparam logic [7:0] PWM_RATE_OFFSET = 8'h27;
	localparam logic [7:0] PWM_RATE_RESET = 8'h00;
	localparam logic [1:0] STRAP_GND = 2'h0;
	localparam logic [1:0] STRAP_SCL = 2'h1;
	localparam logic [1:0] STRAP_SDA = 2'h2;
	localparam logic [1:0] STRAP_VCC = 2'h3;
	localparam int CLOCK_HZ = 200000000;
	localparam int PWM_FAST_HZ = 24000;
	localparam int PWM_SLOW_HZ = 3600;
	localparam int PWM_FAST_CYCLES = CLOCK_HZ / PWM_FAST_HZ;
	localparam int PWM_SLOW_CYCLES = CLOCK_HZ / PWM_SLOW_HZ;
	typedef enum logic [1:0] {STRAP_IS_GND, STRAP_IS_VCC, STRAP_IS_SCL, STRAP_IS_SDA} strap_conn_t;
endpackage : led_port_pkg
`default_nettype wire

// *** core/pwm_rate_gen.sv ***
// pwm period generator, rate picked by a select bit
`default_nettype none
module pwm_rate_gen
	import led_port_pkg::*;
(
	// clocking
	input wire logic clock,
	input wire logic arst_n,
	input wire logic clk_en,
	// control
	input wire logic slow_sel,
	// status
	output logic pwm_period_start
);
	import led_port_pkg::*;
	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} gen_state_t;
	gen_state_t st_r, st_nxt;
	localparam logic [15:0] FAST_LAST = 16'(PWM_FAST_CYCLES - 1);
	localparam logic [15:0] SLOW_LAST = 16'(PWM_SLOW_CYCLES - 1);
	always_comb begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (st_r.cnt >= (slow_sel ? SLOW_LAST : FAST_LAST)) begin // R14
			st_nxt.cnt = 16'h0000;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.cnt = st_r.cnt + 16'h0001;
		end
	end
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end
	assign pwm_period_start = st_r.tick;
	a_fast_period: assert property (@(posedge clock) disable iff (!arst_n) // R14
		(clk_en && st_r.tick && !slow_sel) |-> st_r.cnt == 16'h0000)
		else $error("period counter not restarted");
endmodule : pwm_rate_gen
`default_nettype wire

// *** core/i2c_write_port.sv ***
// write-only serial target with register pointer and pwm rate select
// What this block and the bus master do
// R1: answer address 11011 plus two strap bits, then the direction bit.
// R2: writes only; a set direction bit is never acknowledged, no read path.
// R3: strap ground 00, supply 11, clock line 01, data line 10.
// R4: sample data while clock high, most significant bit first.
// R5: data falling with clock high starts, rising with clock high stops.
// R6: matching address byte acknowledged by holding data low in ninth pulse.
// R7: master releases data for acknowledge and stops if none seen.
// R8: byte after address is the register address, acknowledged.
// R9: every following data byte accepted and acknowledged.
// R10: pointer increments by one during each data acknowledge.
// R11: master keeps data high when the bus is idle.
// R12: master clock at most 400 kHz.
// R13: data line only pulled low or released.
// R14: register pwm_rate_select value 0 gives 24 kHz, 1 gives 3.6 kHz.
// R15: mismatch or read request ignored until next start.
`default_nettype none
module i2c_write_port
	import led_port_pkg::*;
(
	// clocking
	input wire logic clock,
	input wire logic arst_n,
	input wire logic clk_en,
	// serial pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// strap, already resolved to its connection
	input wire led_port_pkg::strap_conn_t strap_conn,
	// register write strobe
	output logic reg_wr,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_data,
	// pwm
	output logic [7:0] pwm_rate_select,
	output logic pwm_tick
);
	import led_port_pkg::*;
	typedef enum logic [2:0] {IDLE, ADDR, REGA, DATA, ACK, IGNORE} phase_t;
	typedef struct packed {
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic scl_d;
		logic sda_d;
		phase_t ph;
		phase_t after_ack;
		logic [3:0] bits;
		logic [7:0] shift;
		logic [7:0] ptr;
		logic ack_drive;
		strap_conn_t strap_s1;
		strap_conn_t strap_s2;
		logic [1:0] target_addr_bits;
		logic wr;
		logic [7:0] wa;
		logic [7:0] wd;
		logic [7:0] rate;
		logic tick;
	} port_state_t;
	port_state_t st_r, st_nxt;
	logic scl, sda, start_seen, stop_seen, scl_rise, scl_fall, rate_tick, byte_end;
	logic [7:0] byte_in;
	function automatic logic [1:0] strap_bits(input strap_conn_t c);
		unique case (c) // R3
			STRAP_IS_GND: strap_bits = STRAP_GND;
			STRAP_IS_VCC: strap_bits = STRAP_VCC;
			STRAP_IS_SCL: strap_bits = STRAP_SCL;
			STRAP_IS_SDA: strap_bits = STRAP_SDA;
		endcase
	endfunction : strap_bits
	// only the second stage of each synchroniser is read
	assign scl = st_r.scl_s[1];
	assign sda = st_r.sda_s[1];
	assign start_seen = scl && st_r.scl_d && st_r.sda_d && !sda; // R5
	assign stop_seen = scl && st_r.scl_d && !st_r.sda_d && sda; // R5
	assign scl_rise = scl && !st_r.scl_d;
	assign scl_fall = !scl && st_r.scl_d;
	assign byte_in = {st_r.shift[6:0], sda}; // R4
	always_comb begin
		st_nxt = st_r;
		st_nxt.scl_s = {st_r.scl_s[0], scl_in};
		st_nxt.sda_s = {st_r.sda_s[0], sda_in};
		st_nxt.scl_d = scl;
		st_nxt.sda_d = sda;
		st_nxt.wr = 1'b0;
		st_nxt.tick = rate_tick;
		// strap caught after reset release, never under reset
		// the strap is a pin too: two flops before the decode reads it
		st_nxt.strap_s1 = strap_conn;
		st_nxt.strap_s2 = st_r.strap_s1;
		st_nxt.target_addr_bits = strap_bits(st_r.strap_s2); // R3
		if (start_seen) begin
			st_nxt.ph = ADDR; // R5
			st_nxt.bits = 4'h0;
			st_nxt.ack_drive = 1'b0;
		end else if (stop_seen) begin
			st_nxt.ph = IDLE; // R5
			st_nxt.ack_drive = 1'b0;
		end else begin
			unique case (st_r.ph)
				IDLE, IGNORE: st_nxt.ack_drive = 1'b0; // R15
				ADDR, REGA, DATA: begin
					if (scl_rise) begin
						st_nxt.shift = byte_in; // R4
						st_nxt.bits = st_r.bits + 4'h1;
					end
					// decide at the falling edge after the eighth bit
					if (scl_fall && st_r.bits == 4'h8) begin
						st_nxt.bits = 4'h0;
						st_nxt.ph = ACK;
						st_nxt.ack_drive = 1'b1;
						if (st_r.ph == ADDR) begin
							if (st_r.shift != {ADDR_UPPER, st_r.target_addr_bits, 1'b0}) begin // R1 R2
								st_nxt.ph = IGNORE; // R15
								st_nxt.ack_drive = 1'b0;
							end
							st_nxt.after_ack = REGA; // R6
						end else if (st_r.ph == REGA) begin
							st_nxt.ptr = st_r.shift; // R8
							st_nxt.after_ack = DATA;
						end else begin
							st_nxt.wr = 1'b1; // R9
							st_nxt.wa = st_r.ptr;
							st_nxt.wd = st_r.shift;
							st_nxt.ptr = st_r.ptr + 8'h01; // R10
							if (st_r.ptr == PWM_RATE_OFFSET) begin
								st_nxt.rate = st_r.shift; // R14
							end
							st_nxt.after_ack = DATA;
						end
					end
				end
				ACK: if (scl_fall) begin
					st_nxt.ack_drive = 1'b0; // R6
					st_nxt.ph = st_r.after_ack;
				end
				default: st_nxt.ph = IDLE;
			endcase
		end
	end
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '{scl_s: 2'h3, sda_s: 2'h3, scl_d: 1'b1, sda_d: 1'b1, ph: IDLE,
				after_ack: IDLE, bits: 4'h0, shift: 8'h00, ptr: 8'h00, ack_drive: 1'b0,
				strap_s1: STRAP_IS_GND, strap_s2: STRAP_IS_GND, target_addr_bits: 2'h0,
				wr: 1'b0, wa: 8'h00, wd: 8'h00,
				rate: PWM_RATE_RESET, tick: 1'b0};
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end
	pwm_rate_gen u_rate (
		.clock(clock),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.slow_sel(st_r.rate[0]), // R14
		.pwm_period_start(rate_tick)
	);
	// open drain: output is always low, only the enable moves
	assign sda_out = 1'b0; // R13
	assign sda_oe = st_r.ack_drive; // R13
	assign reg_wr = st_r.wr;
	assign reg_addr = st_r.wa;
	assign reg_data = st_r.wd;
	assign pwm_rate_select = st_r.rate;
	assign pwm_tick = st_r.tick;
	// byte boundary as the state machine sees it, for the checks below
	assign byte_end = clk_en && scl_fall && st_r.bits == 4'h8 && !start_seen && !stop_seen;
	a_ack_held: assert property (@(posedge clock) disable iff (!arst_n) // R6
		(clk_en && st_r.ph == ACK && st_r.ack_drive && scl && !start_seen && !stop_seen)
		|=> sda_oe)
		else $error("acknowledge dropped during ninth pulse");
	a_addr_ack: assert property (@(posedge clock) disable iff (!arst_n) // R1 R6
		(byte_end && st_r.ph == ADDR
		&& st_r.shift == {ADDR_UPPER, st_r.target_addr_bits, 1'b0}) |=> st_r.ph == ACK && sda_oe)
		else $error("matching address not acknowledged");
	// a foreign address must leave the line alone until the next start
	a_addr_refused: assert property (@(posedge clock) disable iff (!arst_n) // R15
		(byte_end && st_r.ph == ADDR
		&& st_r.shift != {ADDR_UPPER, st_r.target_addr_bits, 1'b0}) |=> st_r.ph == IGNORE)
		else $error("foreign address acknowledged");
	a_ignore_quiet: assert property (@(posedge clock) disable iff (!arst_n) // R15
		st_r.ph == IGNORE |-> !sda_oe)
		else $error("drive while ignoring");
	a_reg_ack: assert property (@(posedge clock) disable iff (!arst_n) // R8
		(byte_end && st_r.ph == REGA) |=> sda_oe && st_r.ptr == $past(st_r.shift))
		else $error("register byte not taken");
	a_data_ack: assert property (@(posedge clock) disable iff (!arst_n) // R9
		(byte_end && st_r.ph == DATA) |=> reg_wr && sda_oe && reg_data == $past(st_r.shift))
		else $error("data byte not taken");
	a_ptr_step: assert property (@(posedge clock) disable iff (!arst_n) // R10
		(clk_en && st_nxt.wr) |=> st_r.ptr == st_r.wa + 8'h01)
		else $error("pointer did not advance");
	a_rate_load: assert property (@(posedge clock) disable iff (!arst_n) // R14
		(clk_en && st_nxt.wr && st_nxt.wa == PWM_RATE_OFFSET) |=> pwm_rate_select == reg_data)
		else $error("rate register not loaded");
	a_stop_idle: assert property (@(posedge clock) disable iff (!arst_n) // R5
		(clk_en && stop_seen) |=> st_r.ph == IDLE && !sda_oe)
		else $error("stop not honoured");
	a_start_addr: assert property (@(posedge clock) disable iff (!arst_n) // R5
		(clk_en && start_seen) |=> st_r.ph == ADDR && st_r.bits == 4'h0)
		else $error("start not honoured");
	a_read_refused: assert property (@(posedge clock) disable iff (!arst_n) // R2
		(byte_end && st_r.ph == ADDR && st_r.shift[0]) |=> st_r.ph == IGNORE)
		else $error("read request acknowledged");
	a_wr_pulse: assert property (@(posedge clock) disable iff (!arst_n) // R9
		(clk_en && reg_wr) |=> !reg_wr)
		else $error("write strobe longer than one cycle");
	a_oe_in_ack: assert property (@(posedge clock) disable iff (!arst_n) // R13
		sda_oe |-> st_r.ph == ACK && !sda_out)
		else $error("data line driven outside acknowledge");
	a_bits_bound: assert property (@(posedge clock) disable iff (!arst_n) // R4
		st_r.bits <= 4'h8)
		else $error("bit counter past a byte");
	c_ack: cover property (@(posedge clock) st_r.ph == ACK && sda_oe);
	c_write: cover property (@(posedge clock) reg_wr);
	c_ignore: cover property (@(posedge clock) st_r.ph == IGNORE);
	c_slow: cover property (@(posedge clock) pwm_rate_select[0]);
	c_data_ack: cover property (@(posedge clock) st_r.ph == ACK && st_r.after_ack == DATA && sda_oe);
endmodule : i2c_write_port
`default_nettype wire

// *** tb/i2c_master_model.sv ***
// serial bus master model for the write port
`default_nettype none
module i2c_master_model (
	// bus
	input wire logic clock,
	input wire logic sda_line,
	output logic scl,
	output logic sda_drv
);
	timeunit 1ns;
	timeprecision 1ps;
	// 500 cycles a bit keeps the clock at 400 kHz, so runs stay long
	localparam int T_LO = 300;
	localparam int T_HI = 200;
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(negedge clock);
	endtask : w
	task automatic start();
		sda_drv = 1'b1;
		w(T_LO);
		scl = 1'b1;
		w(T_HI);
		sda_drv = 1'b0;
		w(T_HI);
		scl = 1'b0;
	endtask : start
	// data moves well after the clock fall so it never looks like a stop
	task automatic bit_io(input logic b, output logic s);
		w(20);
		sda_drv = b;
		w(T_LO - 20);
		scl = 1'b1;
		w(T_HI / 2);
		s = sda_line;
		w(T_HI / 2);
		scl = 1'b0;
	endtask : bit_io
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask : put_byte
	task automatic stop();
		w(20);
		sda_drv = 1'b0;
		w(T_LO);
		scl = 1'b1;
		w(T_HI);
		sda_drv = 1'b1;
		w(2 * T_LO);
	endtask : stop
endmodule : i2c_master_model
`default_nettype wire

// *** tb/testbench.sv ***
// testbench: register writes through the serial port, strobes and pwm rate
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import led_port_pkg::*;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic clk_en = 1'b1;
	strap_conn_t strap_conn = STRAP_IS_GND;
	logic scl, sda_drv, sda_out, sda_oe, reg_wr, pwm_tick;
	logic [7:0] reg_addr, reg_data, pwm_rate_select;
	int err_count = 0;
	int n_tests = 0;
	int gap;
	logic [15:0] exp_q[$];
	logic [1:0] sbits[4] = '{2'h0, 2'h3, 2'h1, 2'h2};
	// pull-up: the line is low whenever any party pulls it
	wire sda_line = sda_drv & ~(sda_oe & ~sda_out);
	always #2.5 clock = ~clock;
	i2c_write_port uut (.clock(clock), .arst_n(arst_n), .clk_en(clk_en), .scl_in(scl),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .strap_conn(strap_conn),
		.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_data(reg_data),
		.pwm_rate_select(pwm_rate_select), .pwm_tick(pwm_tick));
	i2c_master_model mst (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic print_verdict();
		$display("errors %0d checks %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict
	task automatic xfer(input logic [6:0] ta, input logic rw, input logic [7:0] ra,
		input int n, input logic [7:0] last, input logic ok);
		logic a;
		logic [7:0] d;
		mst.start();
		mst.put_byte({ta, rw}, a);
		check(16'(a), 16'(ok));
		if (ok) begin
			mst.put_byte(ra, a);
			check(16'(a), 16'h1);
			for (int i = 0; i < n; i++) begin
				d = (i == n - 1) ? last : 8'($urandom);
				exp_q.push_back({ra + 8'(i), d});
				mst.put_byte(d, a);
				check(16'(a), 16'h1);
			end
		end
		mst.stop();
	endtask : xfer
	task automatic tick_gap();
		gap = 0;
		do begin
			@(negedge clock);
			gap++;
		end while (pwm_tick !== 1'b1 && gap < 60000);
		if (gap >= 60000) begin
			err_count++;
			print_verdict();
		end
	endtask : tick_gap
	// each write strobe takes the oldest note
	always @(negedge clock) begin
		if (reg_wr === 1'b1) begin
			check(16'(exp_q.size() > 0), 16'h1);
			if (exp_q.size() > 0) check({reg_addr, reg_data}, exp_q.pop_front());
		end
	end
	initial begin
		void'($urandom(37921));
		repeat (20) @(negedge clock);
		arst_n = 1'b1;
		check(16'(pwm_rate_select), 16'(PWM_RATE_RESET));
		repeat (5) @(negedge clock);
		for (int s = 0; s < 4; s++) begin
			strap_conn = strap_conn_t'(s);
			repeat (5) @(negedge clock);
			xfer({ADDR_UPPER, sbits[s]}, 1'b0, 8'h25, (s == 3) ? 3 : 0, 8'hFE, 1'b1);
		end
		check(16'(pwm_rate_select), 16'h00FE);
		xfer({ADDR_UPPER, ~sbits[3]}, 1'b0, 8'h27, 1, 8'h01, 1'b0);
		xfer({ADDR_UPPER, sbits[3]}, 1'b1, 8'h27, 1, 8'h01, 1'b0);
		check(16'(pwm_rate_select), 16'h00FE);
		tick_gap();
		// frozen cycles must not count toward the period, so the gap stays whole
		clk_en = 1'b0;
		repeat (100) @(negedge clock);
		clk_en = 1'b1;
		tick_gap();
		check(16'(gap), 16'(PWM_FAST_CYCLES));
		xfer({ADDR_UPPER, sbits[3]}, 1'b0, 8'h27, 1, 8'h01, 1'b1);
		check(16'(pwm_rate_select), 16'h0001);
		check(16'(exp_q.size()), 16'h0);
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
